// *** frc_timer_pkg.sv ***
// Constants shared by the free-running timer: register indices, field positions,
// reset values and cycle counts.
// Assumes registers are reached over a 32-bit Avalon-MM slave, one word each.
package frc_timer_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_TIMER_CONTROL   = 6'h12;
    localparam logic [5:0] IDX_TIMER_STATUS    = 6'h13;
    localparam logic [5:0] IDX_COUNTER_HIGH    = 6'h18;
    localparam logic [5:0] IDX_COUNTER_LOW     = 6'h19;
    localparam logic [5:0] IDX_ALT_COUNTER_HIGH = 6'h1a;
    localparam logic [5:0] IDX_ALT_COUNTER_LOW = 6'h1b;

    // Field positions in the control register.
    localparam int CTL_CAPTURE_IRQ_EN_BIT  = 7;
    localparam int CTL_COMPARE_IRQ_EN_BIT  = 6;
    localparam int CTL_OVERFLOW_IRQ_EN_BIT = 5;
    localparam int CTL_CAPTURE_EDGE_BIT    = 1;
    localparam int CTL_COMPARE_LEVEL_BIT   = 0;
    localparam logic [7:0] CTL_WRITE_MASK  = 8'he3;

    // Field position in the status register.
    localparam int STS_OVERFLOW_FLAG_BIT = 5;

    // Values after reset.
    localparam logic [7:0]  CTL_RESET_VALUE     = 8'h00;
    localparam logic [15:0] COUNTER_PRESET      = 16'hfffc;

    // Counting.
    localparam int COUNTER_WIDTH   = 16;
    localparam int PRESCALE_DIV    = 4;
    localparam int STARTUP_CYCLES  = 4064;
    localparam int ROLLOVER_CYCLES = 262144;

endpackage : frc_timer_pkg

// *** frc_prescaler.sv ***
// Fixed prescaler with a power-on start-up hold for the free-running timer.
// Assumes rst and por come from logic on clk_sys; por marks a power-on reset.
`timescale 1ns/1ps

module frc_prescaler
    import frc_timer_pkg::*;
#(
    parameter int DIV        = PRESCALE_DIV,
    parameter int START_WAIT = STARTUP_CYCLES
) (
    input  wire logic clk_sys,  // System clock.
    input  wire logic rst,      // Synchronous reset, active high.
    input  wire logic por,      // High with rst when the reset is a power-on reset.
    output logic      tick,     // One-cycle count enable.
    output logic      running   // High once the start-up hold is over.
);

    localparam int DW = $clog2(DIV);
    localparam int SW = $clog2(START_WAIT + 1);

    if (DIV < 2) begin : g_bad_div
        $error("frc_prescaler: DIV must be at least 2");
    end
    if (START_WAIT < 1) begin : g_bad_wait
        $error("frc_prescaler: START_WAIT must be at least 1");
    end

    logic [DW-1:0] div_q;
    logic [SW-1:0] wait_q;

    // Only a power-on reset waits for the oscillator; other resets restart at once.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wait_q <= por ? SW'(START_WAIT) : '0;
        end else if (wait_q != '0) begin
            wait_q <= wait_q - SW'(1);
        end
    end

    assign running = (wait_q == '0);

    always_ff @(posedge clk_sys) begin
        if (rst || !running) begin
            div_q <= '0;
        end else if (div_q == DW'(DIV - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DW'(1);
        end
    end

    assign tick = running && (div_q == DW'(DIV - 1));

    chk_tick_spacing: assert property (@(posedge clk_sys) disable iff (rst)
        tick |=> !tick [*3])
        else $error("prescaler tick came early");

endmodule : frc_prescaler

// *** frc_lsb_latch.sv ***
// Low-byte snapshot latch for one high/low counter register pair.
// Assumes rd_high and rd_low are one-cycle pulses on the edge that samples read data.
`timescale 1ns/1ps

module frc_lsb_latch
    import frc_timer_pkg::*;
(
    input  wire logic       clk_sys,  // System clock.
    input  wire logic       rst,      // Synchronous reset, active high.
    input  wire logic [7:0] live_lsb, // Current counter low byte.
    input  wire logic       rd_high,  // High byte read taken this cycle.
    input  wire logic       rd_low,   // Low byte read taken this cycle.
    output logic [7:0]      low_view  // What the low byte register shows.
);

    logic [7:0] held_q;
    logic       frozen_q;

    // The first high read freezes the LSB; later high reads must not refresh it.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            frozen_q <= 1'b0;
            held_q   <= 8'h00;
        end else if (rd_low) begin
            frozen_q <= 1'b0;
        end else if (rd_high && !frozen_q) begin
            frozen_q <= 1'b1;
            held_q   <= live_lsb;
        end
    end

    assign low_view = frozen_q ? held_q : live_lsb;

    chk_lsb_frozen: assert property (@(posedge clk_sys) disable iff (rst)
        frozen_q && !rd_low |=> frozen_q && $stable(held_q))
        else $error("frozen low byte changed before low read");

    chk_lsb_release: assert property (@(posedge clk_sys) disable iff (rst)
        rd_low |=> low_view == live_lsb)
        else $error("low byte not transparent after low read");

endmodule : frc_lsb_latch

// *** frc_timer.sv ***
// Free-running 16-bit timer counter with primary and alternate read pairs.
// Assumes an Avalon-MM master on clk_sys, and rst/por from logic on the same clock.
//
// Function
// - A 16-bit up counter advances once per four clocks and so repeats every 262,144 clocks.
// - Every reset loads the counter with fffc.
// - After a power-on reset the counter holds its preset until the start-up delay ends.
// - Writes to the primary high and low byte registers are ignored.
// - Reading the primary high byte freezes the low byte until the low byte is read.
// - The wrap from ffff to 0000 sets the overflow flag.
// - An interrupt is requested while the overflow flag and its enable are both set.
// - Only a primary low byte read after a status read of the set flag clears the overflow flag.
// - Counter reads in any order or number never disturb the count.
// - The alternate pair shows the same counter and never touches the flag or interrupt.
// - The alternate low byte freezes on an alternate high read until the low read.
// - Writes to the alternate pair change nothing.
// - A high byte read holds its pair until the matching low byte read ends it.
// - The control register sits at index 12 and the status register at index 13.
// - Reset clears the overflow interrupt enable.
`timescale 1ns/1ps

module frc_timer
    import frc_timer_pkg::*;
#(
    parameter int START_WAIT = STARTUP_CYCLES
) (
    input  wire logic        clk_sys,         // System clock, 100 MHz.
    input  wire logic        rst,             // Synchronous reset, active high.
    input  wire logic        por,             // High with rst for a power-on reset.
    input  wire logic [7:0]  avs_address,     // Byte address.
    input  wire logic        avs_read,        // Read request.
    input  wire logic        avs_write,       // Write request.
    input  wire logic [31:0] avs_writedata,   // Write data.
    input  wire logic [3:0]  avs_byteenable,  // Byte lanes of the write.
    output logic      [31:0] avs_readdata,    // Read data, registered.
    output logic             avs_waitrequest, // Stall until the answer is ready.
    output logic             timer_irq,       // Overflow interrupt request, level.
    output logic      [15:0] counter_value    // Live count for capture and compare.
);

    if (COUNTER_WIDTH != 16) begin : g_bad_width
        $error("frc_timer: register pairs serve a 16-bit counter only");
    end

    function automatic logic hits(input logic [7:0] addr, input logic [5:0] idx);
        hits = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
    endfunction : hits

    // Bus slave: one wait state, then the answer. Side effects happen on the
    // first edge of a request, which every request has exactly once.
    logic        ack_q;
    logic        take;
    logic        rd_take;
    logic        wr_take;
    logic [31:0] readdata_q;

    assign take            = (avs_read || avs_write) && !ack_q;
    assign rd_take         = avs_read && !ack_q;
    assign wr_take         = avs_write && !ack_q;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata    = readdata_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= take;
        end
    end

    logic rd_ctl;
    logic rd_sts;
    logic rd_hi;
    logic rd_lo;
    logic rd_alt_hi;
    logic rd_alt_lo;
    logic wr_ctl;

    assign rd_ctl    = rd_take && hits(avs_address, IDX_TIMER_CONTROL);
    assign rd_sts    = rd_take && hits(avs_address, IDX_TIMER_STATUS);
    assign rd_hi     = rd_take && hits(avs_address, IDX_COUNTER_HIGH);
    assign rd_lo     = rd_take && hits(avs_address, IDX_COUNTER_LOW);
    assign rd_alt_hi = rd_take && hits(avs_address, IDX_ALT_COUNTER_HIGH);
    assign rd_alt_lo = rd_take && hits(avs_address, IDX_ALT_COUNTER_LOW);
    // Counter registers decode no write at all, so writes there fall through.
    assign wr_ctl    = wr_take && avs_byteenable[0]
                       && hits(avs_address, IDX_TIMER_CONTROL);

    // Counter and prescaler.
    logic        tick;
    logic        running;
    logic [15:0] counter_q;
    logic        wrap;

    frc_prescaler #(
        .DIV        (PRESCALE_DIV),
        .START_WAIT (START_WAIT)
    ) u_prescaler (
        .clk_sys (clk_sys),
        .rst     (rst),
        .por     (por),
        .tick    (tick),
        .running (running)
    );

    assign wrap = tick && (counter_q == 16'hffff);

    // The counter sees no bus signal at all, so no read can disturb it.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            counter_q <= COUNTER_PRESET;
        end else if (tick) begin
            counter_q <= counter_q + 16'h0001;
        end
    end

    assign counter_value = counter_q;

    // Control register.
    logic [7:0] ctl_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctl_q <= CTL_RESET_VALUE;
        end else if (wr_ctl) begin
            ctl_q <= avs_writedata[7:0] & CTL_WRITE_MASK;
        end
    end

    // Overflow flag and its clear qualifier.
    logic overflow_flag_q;
    logic arm_q;

    // A wrap in the same cycle as the clearing read keeps the flag set.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            overflow_flag_q <= 1'b0;
        end else if (wrap) begin
            overflow_flag_q <= 1'b1;
        end else if (rd_lo && arm_q) begin
            overflow_flag_q <= 1'b0;
        end
    end

    // Alternate reads never reach the qualifier or the flag.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            arm_q <= 1'b0;
        end else if (rd_lo) begin
            arm_q <= 1'b0;
        end else if (rd_sts && overflow_flag_q) begin
            arm_q <= 1'b1;
        end
    end

    assign timer_irq = overflow_flag_q && ctl_q[CTL_OVERFLOW_IRQ_EN_BIT];

    // Low byte snapshots for each pair. Software should mask interrupts across
    // a pair so that another reader does not split it.
    logic [7:0] lo_view;
    logic [7:0] alt_lo_view;

    frc_lsb_latch u_primary_lsb (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .live_lsb (counter_q[7:0]),
        .rd_high  (rd_hi),
        .rd_low   (rd_lo),
        .low_view (lo_view)
    );

    frc_lsb_latch u_alt_lsb (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .live_lsb (counter_q[7:0]),
        .rd_high  (rd_alt_hi),
        .rd_low   (rd_alt_lo),
        .low_view (alt_lo_view)
    );

    // Read data is captured on the same edge as the snapshot, so the first high read
    // and the frozen LSB come from one count.
    logic [7:0] status_byte;

    always_comb begin
        status_byte = 8'h00;
        status_byte[STS_OVERFLOW_FLAG_BIT] = overflow_flag_q;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            readdata_q <= 32'h0000_0000;
        end else if (rd_take) begin
            if (rd_ctl) begin
                readdata_q <= {24'h00_0000, ctl_q};
            end else if (rd_sts) begin
                readdata_q <= {24'h00_0000, status_byte};
            end else if (rd_hi || rd_alt_hi) begin
                readdata_q <= {24'h00_0000, counter_q[15:8]};
            end else if (rd_lo) begin
                readdata_q <= {24'h00_0000, lo_view};
            end else if (rd_alt_lo) begin
                readdata_q <= {24'h00_0000, alt_lo_view};
            end else begin
                readdata_q <= 32'h0000_0000;
            end
        end
    end

    // Checks.
    chk_reset_preset: assert property (@(posedge clk_sys)
        rst |=> counter_q == COUNTER_PRESET)
        else $error("counter not preset by reset");

    chk_count_step: assert property (@(posedge clk_sys) disable iff (rst)
        tick |=> counter_q == $past(counter_q) + 16'h0001)
        else $error("counter did not advance on tick");

    chk_count_only_tick: assert property (@(posedge clk_sys) disable iff (rst)
        !tick |=> $stable(counter_q))
        else $error("counter moved without a tick");

    chk_startup_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !running |-> counter_q == COUNTER_PRESET)
        else $error("counter left preset during start-up hold");

    chk_overflow_set: assert property (@(posedge clk_sys) disable iff (rst)
        wrap |=> overflow_flag_q && counter_q == 16'h0000)
        else $error("wrap did not set overflow flag");

    // A reset also drops the flag and the control bits, so the first edge
    // after release must not blame a bus access for that change.
    chk_flag_clear_cause: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(overflow_flag_q) && !$past(rst) |-> $past(rd_lo) && $past(arm_q))
        else $error("overflow flag cleared without armed low read");

    chk_alt_no_flag: assert property (@(posedge clk_sys) disable iff (rst)
        (rd_alt_hi || rd_alt_lo) && overflow_flag_q |=> overflow_flag_q)
        else $error("alternate read cleared overflow flag");

    chk_irq_follows: assert property (@(posedge clk_sys) disable iff (rst)
        wrap && ctl_q[CTL_OVERFLOW_IRQ_EN_BIT] && !wr_ctl |=> timer_irq)
        else $error("overflow did not raise interrupt");

    chk_ctl_write_only: assert property (@(posedge clk_sys) disable iff (rst)
        $changed(ctl_q) && !$past(rst) |-> $past(wr_ctl))
        else $error("control changed without a control write");

    chk_enable_reset: assert property (@(posedge clk_sys)
        rst |=> !timer_irq && !ctl_q[CTL_OVERFLOW_IRQ_EN_BIT])
        else $error("overflow enable not cleared by reset");

    chk_arm_needs_flag: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(arm_q) |-> $past(rd_sts) && $past(overflow_flag_q))
        else $error("clear qualifier armed without status read of set flag");

    chk_bus_answer: assert property (@(posedge clk_sys) disable iff (rst)
        take |=> (avs_read || avs_write) |-> !avs_waitrequest)
        else $error("bus answer later than one wait state");

    chk_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        overflow_flag_q && !(rd_lo && arm_q) |=> overflow_flag_q)
        else $error("overflow flag dropped without a clearing read");

    chk_flag_only_wrap: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(overflow_flag_q) |-> $past(wrap))
        else $error("overflow flag set without a wrap");

    chk_arm_clear: assert property (@(posedge clk_sys) disable iff (rst)
        rd_lo |=> !arm_q)
        else $error("clear qualifier kept after a low byte read");

    chk_alt_no_arm: assert property (@(posedge clk_sys) disable iff (rst)
        rd_alt_hi || rd_alt_lo |=> $stable(arm_q))
        else $error("alternate read touched the clear qualifier");

    chk_write_no_flag: assert property (@(posedge clk_sys) disable iff (rst)
        wr_take && !wrap |=> overflow_flag_q == $past(overflow_flag_q))
        else $error("write changed the overflow flag");

    chk_write_ignored: assert property (@(posedge clk_sys) disable iff (rst)
        wr_take && !wr_ctl |=> $stable(ctl_q) && $stable(arm_q))
        else $error("write outside control changed a register");

    chk_ctl_mask: assert property (@(posedge clk_sys) disable iff (rst)
        wr_ctl |=> ctl_q == ($past(avs_writedata[7:0]) & CTL_WRITE_MASK))
        else $error("control write not stored through its mask");

    chk_hi_data: assert property (@(posedge clk_sys) disable iff (rst)
        rd_hi |=> avs_readdata[7:0] == $past(counter_q[15:8]))
        else $error("high byte read did not return the count");

    chk_alt_hi_data: assert property (@(posedge clk_sys) disable iff (rst)
        rd_alt_hi |=> avs_readdata[7:0] == $past(counter_q[15:8]))
        else $error("alternate high byte read did not return the count");

    chk_status_bits: assert property (@(posedge clk_sys) disable iff (rst)
        rd_sts |=> avs_readdata == {26'h000_0000, $past(overflow_flag_q), 5'h00})
        else $error("status read did not show the overflow flag");

    chk_irq_needs_flag: assert property (@(posedge clk_sys) disable iff (rst)
        !overflow_flag_q |-> !timer_irq)
        else $error("interrupt requested without overflow flag");

    chk_rd_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bytes not zero");

endmodule : frc_timer

// *** frc_cpu_model.sv ***
// Processor-side model: an Avalon-MM master that makes one request at a time.
// Assumes the timer slave on clk_sys, answering with waitrequest.
`timescale 1ns/1ps

module frc_cpu_model (
    input  wire logic        clk_sys,         // System clock.
    input  wire logic        avs_waitrequest, // Slave stall.
    output logic      [7:0]  avs_address,     // Byte address.
    output logic             avs_read,        // Read request.
    output logic             avs_write,       // Write request.
    output logic      [31:0] avs_writedata,   // Write data.
    output logic      [3:0]  avs_byteenable   // Write lanes.
);
    initial begin
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'h0;
    end

    // The request is held until waitrequest is seen low at a rising edge.
    // When last is clear the request stays up, so a next call follows back to back
    // without the strobe being written twice in one time step.
    // Released address and data lines show the inverse of the last value; byteenable keeps its last value.
    task automatic access(input logic we, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] be, input bit last);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= ~we;
        avs_write      <= we;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        if (last) begin
            avs_read      <= 1'b0;
            avs_write     <= 1'b0;
            avs_address   <= ~a;
            avs_writedata <= ~d;
        end
    endtask : access
endmodule : frc_cpu_model

// *** free_running_timer_counter_bench.sv ***
// Self-checking bench for the free-running timer: count, latches, flag and control.
// Assumes frc_timer and frc_cpu_model compiled with frc_timer_pkg.
`timescale 1ns/1ps

module free_running_timer_counter_bench;
    import frc_timer_pkg::*;
    localparam int         SW    = 8;
    localparam logic [7:0] A_CTL = {IDX_TIMER_CONTROL, 2'b00};
    localparam logic [7:0] A_STS = {IDX_TIMER_STATUS, 2'b00};
    localparam logic [7:0] A_HI  = {IDX_COUNTER_HIGH, 2'b00};
    localparam logic [7:0] A_LO  = {IDX_COUNTER_LOW, 2'b00};
    localparam logic [7:0] A_AHI = {IDX_ALT_COUNTER_HIGH, 2'b00};
    localparam logic [7:0] A_ALO = {IDX_ALT_COUNTER_LOW, 2'b00};
    localparam logic [31:0] FLAG = 32'h1 << STS_OVERFLOW_FLAG_BIT;
    logic        clk_sys, rst, por, avs_read, avs_write, avs_waitrequest, timer_irq;
    logic [7:0]  avs_address, frz_p, frz_a;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [3:0]  avs_byteenable;
    logic [15:0] counter_value, ref_q;
    logic [1:0]  div_q;
    logic        track, lat_p, lat_a;
    logic [31:0] exp_q[$];
    int          error_cnt, comparisons, cycles, seed, n;

    frc_timer #(.START_WAIT(SW)) DUT (.clk_sys(clk_sys), .rst(rst), .por(por),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .timer_irq(timer_irq), .counter_value(counter_value));
    frc_cpu_model cpu (.clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Reference count: one step every fourth clock after a plain reset.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ref_q <= COUNTER_PRESET;
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) ref_q <= ref_q + 16'h1;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    // The expected word is noted at the edge that takes the read; counter words come from the reference.
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input bit last);
        logic [31:0] x;
        x = e;
        fork
            cpu.access(1'b0, a, 32'h0, 4'hf, last);
            begin
                @(posedge clk_sys);
                if (a == A_HI || a == A_AHI) x = {24'h0, ref_q[15:8]};
                if (a == A_LO) x = {24'h0, lat_p ? frz_p : ref_q[7:0]};
                if (a == A_ALO) x = {24'h0, lat_a ? frz_a : ref_q[7:0]};
                if (a == A_HI && !lat_p) frz_p = ref_q[7:0];
                if (a == A_AHI && !lat_a) frz_a = ref_q[7:0];
                lat_p = (a == A_HI) || (lat_p && a != A_LO);
                lat_a = (a == A_AHI) || (lat_a && a != A_ALO);
                exp_q.push_back(x);
            end
        join
    endtask : rd

    always @(posedge clk_sys) begin
        cycles++;
        if (track) chk("counter_value", {16'h0, ref_q}, {16'h0, counter_value});
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() > 0)
                chk("avs_readdata", exp_q.pop_front(), avs_readdata);
            else
                chk("readdata note", 32'h1, 32'h0);
        end
        if (cycles == 3000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        seed = 35031;
        error_cnt = 0;
        comparisons = 0;
        cycles = 0;
        track = 1'b0;
        lat_p = 1'b0;
        lat_a = 1'b0;
        frz_p = 8'h00;
        frz_a = 8'h00;
        rst = 1'b1;
        por = 1'b1;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (SW) begin
            @(posedge clk_sys);
            chk("held count", {16'h0, COUNTER_PRESET}, {16'h0, counter_value});
        end
        repeat (SW + 8) @(posedge clk_sys);
        chk("count started", 32'h1, {31'h0, counter_value != COUNTER_PRESET});
        $display("test power_on_hold done");
        rst <= 1'b1;
        por <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        track <= 1'b1;
        @(posedge clk_sys);
        rd(A_CTL, {24'h0, CTL_RESET_VALUE}, 1'b0);
        rd(A_STS, 32'h0, 1'b0);
        rd(8'h4d, 32'h0, 1'b1);
        repeat (20) @(posedge clk_sys);
        rd(A_LO, 32'h0, 1'b0);
        rd(A_STS, FLAG, 1'b1);
        chk("timer_irq", 32'h0, {31'h0, timer_irq});
        @(posedge clk_sys);
        cpu.access(1'b1, A_CTL, 32'h20, 4'hf, 1'b1);
        @(posedge clk_sys);
        chk("timer_irq", 32'h1, {31'h0, timer_irq});
        d = $random(seed);
        cpu.access(1'b1, A_CTL, d, 4'he, 1'b0);
        rd(A_CTL, 32'h20, 1'b0);
        cpu.access(1'b1, A_CTL, d, 4'hf, 1'b0);
        rd(A_CTL, d & {24'h0, CTL_WRITE_MASK}, 1'b0);
        cpu.access(1'b1, A_CTL, 32'h20, 4'h1, 1'b1);
        @(posedge clk_sys);
        $display("test control_and_flag done");
        rd(A_AHI, 32'h0, 1'b0);
        rd(A_ALO, 32'h0, 1'b0);
        cpu.access(1'b1, A_STS, 32'hffffffff, 4'hf, 1'b0);
        rd(A_STS, FLAG, 1'b0);
        rd(A_LO, 32'h0, 1'b0);
        rd(A_STS, 32'h0, 1'b1);
        chk("timer_irq", 32'h0, {31'h0, timer_irq});
        $display("test flag_clear done");
        @(posedge clk_sys);
        rd(A_HI, 32'h0, 1'b1);
        repeat (9) @(posedge clk_sys);
        rd(A_AHI, 32'h0, 1'b0);
        n = ($random(seed) & 3) + 1;
        repeat (n) rd(A_HI, 32'h0, 1'b0);
        cpu.access(1'b1, A_LO, $random(seed), 4'hf, 1'b0);
        cpu.access(1'b1, A_HI, $random(seed), 4'hf, 1'b0);
        cpu.access(1'b1, A_AHI, $random(seed), 4'hf, 1'b0);
        cpu.access(1'b1, A_ALO, $random(seed), 4'hf, 1'b1);
        repeat (9) @(posedge clk_sys);
        rd(A_ALO, 32'h0, 1'b0);
        rd(A_AHI, 32'h0, 1'b0);
        rd(A_LO, 32'h0, 1'b0);
        rd(A_LO, 32'h0, 1'b0);
        rd(A_ALO, 32'h0, 1'b0);
        rd(A_STS, 32'h0, 1'b0);
        rd(A_CTL, 32'h20, 1'b1);
        $display("test latches done");
        repeat (4) @(posedge clk_sys);
        close_out();
    end
endmodule : free_running_timer_counter_bench
